// >>> logic/mars_alu.sv
/*
  Execution datapath for rotates, subtracts, skips, set, swap, table reads
  and exclusive-OR. Holds the accumulator, flags and table-high latch.
  Assumes decode upstream presents one request per machine cycle, supplies
  the memory operand, and takes mem_wr_q with mem_wdata_q as a write-back.
*/
`timescale 1ns/100ps
module mars_alu
#(
  parameter int unsigned PC_W   = mars_pkg::PC_W,
  parameter int unsigned PAGE_W = mars_pkg::PAGE_W
)
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire mars_pkg::mars_req_t  req,
  input  wire logic [PC_W-1:0]      prog_counter,
  input  wire logic [PAGE_W-1:0]    table_pointer,
  input  wire logic [15:0]          prog_rdata,
  output logic [PC_W-1:0]           prog_addr_q,
  output logic                      prog_rd_q,
  output logic [7:0]                acc_q,
  output mars_pkg::mars_flags_t     flags_q,
  output logic [7:0]                table_high_latch_q,
  output logic                      mem_wr_q,
  output logic [7:0]                mem_wdata_q,
  output logic                      skip_q,
  output logic                      busy_q
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    mars_pkg::mars_state_t state;
    logic [7:0]            acc;
    mars_pkg::mars_flags_t flags;
    logic [7:0]            tbl_high;
    logic                  mem_wr;
    logic [7:0]            mem_wdata;
    logic                  skip;
    logic                  busy;
    logic                  prog_rd;
    logic [PC_W-1:0]       prog_addr;
  } mars_alu_state_t;

  localparam mars_alu_state_t STATE_RESET = '{
    state:     mars_pkg::MARS_ST_IDLE,
    acc:       mars_pkg::BYTE_RESET,
    flags:     '0,
    tbl_high:  mars_pkg::BYTE_RESET,
    mem_wr:    1'b0,
    mem_wdata: mars_pkg::BYTE_RESET,
    skip:      1'b0,
    busy:      1'b0,
    prog_rd:   1'b0,
    prog_addr: '0
  };

  mars_alu_state_t s_q;
  mars_alu_state_t s_d;
  logic            rst_meta_q;
  logic            rst_sync_q;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  // The release is synchronised so all state leaves reset on the same edge.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================================
  // Subtractor and table address
  // ==========================================================================
  logic [7:0]          sub_rhs;
  logic                sub_cin;
  mars_pkg::mars_sub_t sub_res;
  logic                tbl_last;
  logic [PC_W-1:0]     tbl_addr;

  always_comb
  begin
    sub_rhs = (req.op == mars_pkg::MARS_OP_SUB_IMM) ? req.imm_data
                                                    : req.mem_data;
    // Plain subtract behaves as borrow-subtract with no borrow pending.
    sub_cin = (req.op == mars_pkg::MARS_OP_SBC_ACC ||
               req.op == mars_pkg::MARS_OP_SBC_MEM) ? s_q.flags.carry
                                                    : 1'b1;
    tbl_last = (req.op == mars_pkg::MARS_OP_TBL_LAST);
  end

  mars_subtractor u_sub
  (
    .minuend    (s_q.acc),
    .subtrahend (sub_rhs),
    .carry_in   (sub_cin),
    .result     (sub_res)
  );

  mars_table_reader #(.PC_W(PC_W), .PAGE_W(PAGE_W)) u_tbl
  (
    .last_page     (tbl_last),
    .prog_counter  (prog_counter),
    .table_pointer (table_pointer),
    .prog_addr     (tbl_addr)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic [7:0] m;
  logic [7:0] inc_val;
  logic [7:0] dec_val;
  logic [7:0] xor_val;
  logic [7:0] bit_mask;
  logic       take;
  logic       two_cycle;

  always_comb
  begin
    s_d         = s_q;
    m           = req.mem_data;
    inc_val     = m + mars_pkg::BYTE_ONE;
    dec_val     = m - mars_pkg::BYTE_ONE;
    xor_val     = s_q.acc ^ ((req.op == mars_pkg::MARS_OP_XOR_IMM)
                             ? req.imm_data : m);
    bit_mask    = mars_pkg::BYTE_ONE << req.bit_sel;
    take        = 1'b0;
    // Every conditional skip spends the dummy slot, taken or not, so the
    // fetch timing never depends on operand data.
    two_cycle   = req.op inside {[mars_pkg::MARS_OP_DSKIP_MEM :
                                  mars_pkg::MARS_OP_COPY_NULL]};
    s_d.mem_wr  = 1'b0;
    s_d.skip    = 1'b0;
    s_d.prog_rd = 1'b0;
    unique case (s_q.state)
      mars_pkg::MARS_ST_DUMMY:
      begin
        // Dummy slot while the next instruction is fetched and, when the
        // skip was taken, dropped. A request shown now is ignored, so the
        // decode upstream must hold it for one more cycle.
        s_d.busy  = 1'b0;
        s_d.state = mars_pkg::MARS_ST_IDLE;
      end
      mars_pkg::MARS_ST_TABLE:
      begin
        s_d.mem_wr    = 1'b1;
        s_d.mem_wdata = prog_rdata[7:0];
        s_d.tbl_high  = prog_rdata[15:8];
        s_d.busy      = 1'b0;
        s_d.state     = mars_pkg::MARS_ST_IDLE;
      end
      mars_pkg::MARS_ST_IDLE:
      begin
        if (req.valid)
        begin
          unique case (req.op)
            mars_pkg::MARS_OP_RL_ACC:
              s_d.acc = {m[6:0], m[7]};
            mars_pkg::MARS_OP_RLC_MEM:
            begin
              s_d.mem_wr      = 1'b1;
              s_d.mem_wdata   = {m[6:0], s_q.flags.carry};
              s_d.flags.carry = m[mars_pkg::SIGN_BIT];
            end
            mars_pkg::MARS_OP_RLC_ACC:
            begin
              s_d.acc         = {m[6:0], s_q.flags.carry};
              s_d.flags.carry = m[mars_pkg::SIGN_BIT];
            end
            mars_pkg::MARS_OP_RR_MEM:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = {m[0], m[7:1]};
            end
            mars_pkg::MARS_OP_RR_ACC:
              s_d.acc = {m[0], m[7:1]};
            mars_pkg::MARS_OP_RRC_MEM:
            begin
              s_d.mem_wr      = 1'b1;
              s_d.mem_wdata   = {s_q.flags.carry, m[7:1]};
              s_d.flags.carry = m[mars_pkg::LSB_BIT];
            end
            mars_pkg::MARS_OP_RRC_ACC:
            begin
              s_d.acc         = {s_q.flags.carry, m[7:1]};
              s_d.flags.carry = m[mars_pkg::LSB_BIT];
            end
            mars_pkg::MARS_OP_SBC_ACC,
            mars_pkg::MARS_OP_SUB_ACC,
            mars_pkg::MARS_OP_SUB_IMM:
            begin
              s_d.acc   = sub_res.diff;
              s_d.flags = sub_res.flags;
            end
            mars_pkg::MARS_OP_SBC_MEM,
            mars_pkg::MARS_OP_SUB_MEM:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = sub_res.diff;
              s_d.flags     = sub_res.flags;
            end
            mars_pkg::MARS_OP_DSKIP_MEM:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = dec_val;
              take          = (dec_val == mars_pkg::BYTE_RESET);
            end
            mars_pkg::MARS_OP_DSKIP_ACC:
            begin
              s_d.acc = dec_val;
              take    = (dec_val == mars_pkg::BYTE_RESET);
            end
            mars_pkg::MARS_OP_ISKIP_MEM:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = inc_val;
              take          = (inc_val == mars_pkg::BYTE_RESET);
            end
            mars_pkg::MARS_OP_ISKIP_ACC:
            begin
              s_d.acc = inc_val;
              take    = (inc_val == mars_pkg::BYTE_RESET);
            end
            mars_pkg::MARS_OP_BIT_SET_SK:
              take = m[req.bit_sel];
            mars_pkg::MARS_OP_BIT_CLR_SK:
              take = ~m[req.bit_sel];
            mars_pkg::MARS_OP_NULL_SK:
              take = (m == mars_pkg::BYTE_RESET);
            mars_pkg::MARS_OP_COPY_NULL:
            begin
              s_d.acc = m;
              take    = (m == mars_pkg::BYTE_RESET);
            end
            mars_pkg::MARS_OP_SET_BYTE:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = mars_pkg::BYTE_ONES;
            end
            mars_pkg::MARS_OP_SET_BIT:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = m | bit_mask;
            end
            mars_pkg::MARS_OP_SWAP_MEM:
            begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_wdata = {m[3:0], m[7:4]};
            end
            mars_pkg::MARS_OP_SWAP_ACC:
              s_d.acc = {m[3:0], m[7:4]};
            mars_pkg::MARS_OP_TBL_CUR,
            mars_pkg::MARS_OP_TBL_LAST:
            begin
              // Table reads stall one cycle for the program memory fetch.
              s_d.prog_rd   = 1'b1;
              s_d.prog_addr = tbl_addr;
              s_d.busy      = 1'b1;
              s_d.state     = mars_pkg::MARS_ST_TABLE;
            end
            mars_pkg::MARS_OP_XOR_ACC,
            mars_pkg::MARS_OP_XOR_IMM:
            begin
              s_d.acc        = xor_val;
              s_d.flags.zero = (xor_val == mars_pkg::BYTE_RESET);
            end
            mars_pkg::MARS_OP_XOR_MEM:
            begin
              s_d.mem_wr     = 1'b1;
              s_d.mem_wdata  = xor_val;
              s_d.flags.zero = (xor_val == mars_pkg::BYTE_RESET);
            end
            // Unknown operation codes leave every register untouched except mem_wr, skip and prog_rd, which clear.
            default:
            begin
              s_d.mem_wr = 1'b0;
            end
          endcase
          if (two_cycle)
          begin
            s_d.skip  = take;
            s_d.busy  = 1'b1;
            s_d.state = mars_pkg::MARS_ST_DUMMY;
          end
        end
      end
      // An illegal state code falls back to idle, so an upset cannot
      // leave the datapath refusing requests for good.
      default:
      begin
        s_d.state = mars_pkg::MARS_ST_IDLE;
        s_d.busy  = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // The reset branch loads constants only; release timing is the sync's.
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Outputs are plain copies of the state register, so every one of them
  // comes straight from a flip-flop and carries no decode glitches.
  always_comb
  begin
    acc_q              = s_q.acc;
    flags_q            = s_q.flags;
    table_high_latch_q = s_q.tbl_high;
    mem_wr_q           = s_q.mem_wr;
    mem_wdata_q        = s_q.mem_wdata;
    skip_q             = s_q.skip;
    busy_q             = s_q.busy;
    prog_rd_q          = s_q.prog_rd;
    prog_addr_q        = s_q.prog_addr;
  end

endmodule : mars_alu

// >>> logic/mars_pkg.sv
/*
  Constants and types for the rotate, subtract, skip, set, swap, table read
  and exclusive-OR execution datapath of an 8-bit core.
  Assumes a single core clock and that instruction decode happens upstream.
*/
package mars_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PROG_W = 16;
  localparam int unsigned PC_W   = 11;
  localparam int unsigned PAGE_W = 8;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [7:0]  BYTE_ONES  = 8'hFF;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam int unsigned SIGN_BIT   = 7;
  localparam int unsigned LSB_BIT    = 0;

  // ==========================================================================
  // Operation codes
  // ==========================================================================
  typedef enum logic [4:0] {
    MARS_OP_NONE        = 5'h00,
    MARS_OP_RL_ACC      = 5'h01,
    MARS_OP_RLC_MEM     = 5'h02,
    MARS_OP_RLC_ACC     = 5'h03,
    MARS_OP_RR_MEM      = 5'h04,
    MARS_OP_RR_ACC      = 5'h05,
    MARS_OP_RRC_MEM     = 5'h06,
    MARS_OP_RRC_ACC     = 5'h07,
    MARS_OP_SBC_ACC     = 5'h08,
    MARS_OP_SBC_MEM     = 5'h09,
    MARS_OP_SUB_ACC     = 5'h0A,
    MARS_OP_SUB_MEM     = 5'h0B,
    MARS_OP_SUB_IMM     = 5'h0C,
    MARS_OP_DSKIP_MEM   = 5'h0D,
    MARS_OP_DSKIP_ACC   = 5'h0E,
    MARS_OP_ISKIP_MEM   = 5'h0F,
    MARS_OP_ISKIP_ACC   = 5'h10,
    MARS_OP_BIT_SET_SK  = 5'h11,
    MARS_OP_BIT_CLR_SK  = 5'h12,
    MARS_OP_NULL_SK     = 5'h13,
    MARS_OP_COPY_NULL   = 5'h14,
    MARS_OP_SET_BYTE    = 5'h15,
    MARS_OP_SET_BIT     = 5'h16,
    MARS_OP_SWAP_MEM    = 5'h17,
    MARS_OP_SWAP_ACC    = 5'h18,
    MARS_OP_TBL_CUR     = 5'h19,
    MARS_OP_TBL_LAST    = 5'h1A,
    MARS_OP_XOR_ACC     = 5'h1B,
    MARS_OP_XOR_MEM     = 5'h1C,
    MARS_OP_XOR_IMM     = 5'h1D
  } mars_op_t;

  typedef enum logic [1:0] {
    MARS_ST_IDLE  = 2'b00,
    MARS_ST_DUMMY = 2'b01,
    MARS_ST_TABLE = 2'b10
  } mars_state_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic        carry;
    logic        zero;
    logic        nibble_carry_flag;
    logic        signed_wrap_flag;
  } mars_flags_t;

  typedef struct packed {
    logic        valid;
    mars_op_t    op;
    logic [2:0]  bit_sel;
    logic [7:0]  mem_data;
    logic [7:0]  imm_data;
  } mars_req_t;

  typedef struct packed {
    logic [7:0]  diff;
    mars_flags_t flags;
  } mars_sub_t;

endpackage : mars_pkg

// >>> logic/mars_subtractor.sv
/*
  Eight-bit subtractor with inverted borrow input and full flag set.
  Assumes purely combinational use by the datapath around it.
*/
`timescale 1ns/100ps
module mars_subtractor
(
  input  wire logic [7:0]        minuend,
  input  wire logic [7:0]        subtrahend,
  input  wire logic              carry_in,
  output mars_pkg::mars_sub_t    result
);

  logic [8:0] wide;
  logic [4:0] low;

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  always_comb
  begin
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carry_in};
    low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
           - {4'h0, ~carry_in};
    result.diff                    = wide[7:0];
    result.flags.carry             = ~wide[8];
    result.flags.zero              = (wide[7:0] == mars_pkg::BYTE_RESET);
    result.flags.nibble_carry_flag = ~low[4];
    result.flags.signed_wrap_flag  = (minuend[7] ^ subtrahend[7])
                                     & (minuend[7] ^ wide[7]);
  end

endmodule : mars_subtractor

// >>> logic/mars_table_reader.sv
/*
  Forms the program memory address for table reads; mars_alu captures the word.
  Assumes program memory answers one cycle after the address is given.
*/
`timescale 1ns/100ps
module mars_table_reader
#(
  parameter int unsigned PC_W   = mars_pkg::PC_W,
  parameter int unsigned PAGE_W = mars_pkg::PAGE_W
)
(
  input  wire logic              last_page,
  input  wire logic [PC_W-1:0]   prog_counter,
  input  wire logic [PAGE_W-1:0] table_pointer,
  output logic      [PC_W-1:0]   prog_addr
);

  // ==========================================================================
  // Address forming
  // ==========================================================================
  always_comb
  begin
    if (last_page)
    begin
      prog_addr = {{(PC_W-PAGE_W){1'b1}}, table_pointer};
    end
    else
    begin
      prog_addr = {prog_counter[PC_W-1:PAGE_W], table_pointer};
    end
  end

endmodule : mars_table_reader

// >>> testbench/mars_alu_monitor.sv
/*
  Concurrent checks on the ports of the execution datapath.
  Assumes one core clock and requests that follow the hand-over contract.
*/
`timescale 1ns/100ps
module mars_alu_monitor
#(
  parameter int unsigned PC_W   = mars_pkg::PC_W,
  parameter int unsigned PAGE_W = mars_pkg::PAGE_W
)
(
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire mars_pkg::mars_req_t   req,
  input wire logic [PC_W-1:0]       prog_counter,
  input wire logic [PAGE_W-1:0]     table_pointer,
  input wire logic [15:0]           prog_rdata,
  input wire logic [PC_W-1:0]       prog_addr_q,
  input wire logic                  prog_rd_q,
  input wire logic [7:0]            acc_q,
  input wire mars_pkg::mars_flags_t flags_q,
  input wire logic [7:0]            table_high_latch_q,
  input wire logic                  mem_wr_q,
  input wire logic [7:0]            mem_wdata_q,
  input wire logic                  skip_q,
  input wire logic                  busy_q
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // A request only counts on an edge where the datapath is not busy.
  logic take;
  assign take = req.valid && !busy_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_rot_acc;
    take && req.op == mars_pkg::MARS_OP_RL_ACC |=> !mem_wr_q && $stable(flags_q)
      && acc_q == {$past(req.mem_data[6:0]), $past(req.mem_data[7])};
  endproperty
  a_rot_acc: assert property (p_rot_acc) else $error("rotate left bad");
  property p_sub_carry;
    take && req.op == mars_pkg::MARS_OP_SUB_ACC
      |=> flags_q.carry == ($past(acc_q) >= $past(req.mem_data));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("carry bad");
  property p_set_byte;
    take && req.op == mars_pkg::MARS_OP_SET_BYTE
      |=> mem_wr_q && mem_wdata_q == 8'hFF && $stable(flags_q);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("set bad");
  property p_swap_acc;
    take && req.op == mars_pkg::MARS_OP_SWAP_ACC |=> !mem_wr_q
      && acc_q == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])};
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap bad");
  property p_xor_zero;
    take && req.op == mars_pkg::MARS_OP_XOR_ACC |=> $stable(flags_q.carry)
      && flags_q.zero == (acc_q == 8'h00) && $stable(flags_q.signed_wrap_flag);
  endproperty
  a_xor_zero: assert property (p_xor_zero) else $error("xor");
  property p_null_skip;
    take && req.op == mars_pkg::MARS_OP_NULL_SK
      |=> !mem_wr_q && skip_q == ($past(req.mem_data) == 8'h00);
  endproperty
  a_null_skip: assert property (p_null_skip) else $error("null skip");
  property p_bit_set;
    take && req.op == mars_pkg::MARS_OP_BIT_SET_SK
      |=> skip_q == $past(req.mem_data[req.bit_sel]);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit skip bad");
  property p_skip_busy;
    take && req.op inside
      {[mars_pkg::MARS_OP_DSKIP_MEM : mars_pkg::MARS_OP_COPY_NULL]}
      |=> busy_q ##1 !busy_q && !skip_q;
  endproperty
  a_skip_busy: assert property (p_skip_busy) else $error("skip slot");
  property p_tbl_word;
    take && req.op == mars_pkg::MARS_OP_TBL_CUR |=> prog_rd_q ##1 mem_wr_q
      && mem_wdata_q == $past(prog_rdata[7:0])
      && table_high_latch_q == $past(prog_rdata[15:8]);
  endproperty
  a_tbl_word: assert property (p_tbl_word) else $error("table word");
  property p_last_addr;
    take && req.op == mars_pkg::MARS_OP_TBL_LAST |=> prog_rd_q
      && prog_addr_q == {{(PC_W-PAGE_W){1'b1}}, $past(table_pointer)};
  endproperty
  a_last_addr: assert property (p_last_addr) else $error("last page");
endmodule : mars_alu_monitor

bind mars_alu mars_alu_monitor #(.PC_W(PC_W), .PAGE_W(PAGE_W)) mon_u
(
  .clk(clk), .nrst(nrst), .req(req), .prog_counter(prog_counter),
  .table_pointer(table_pointer), .prog_rdata(prog_rdata),
  .prog_addr_q(prog_addr_q), .prog_rd_q(prog_rd_q), .acc_q(acc_q),
  .flags_q(flags_q), .table_high_latch_q(table_high_latch_q),
  .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q), .skip_q(skip_q),
  .busy_q(busy_q)
);

// >>> testbench/mars_alu_bench.sv
/*
  Self-checking bench for the execution datapath with a reference model.
  Assumes the monitor is bound to the datapath and a 200 MHz core clock.
*/
`timescale 1ns/100ps
module mars_alu_bench;
  // ==========================================================================
  // Stimulus and model state
  // ==========================================================================
  // Masks are indexed by op code: memory writer, accumulator writer,
  // two-cycle skip, and subtract groups.
  localparam logic [31:0] MEMD  = 32'h16E0AA54;
  localparam logic [31:0] ACCD  = 32'h291155AA;
  localparam logic [31:0] SKIPS = 32'h001FE000;
  localparam logic [31:0] SUBS  = 32'h00001F00;
  logic                  clk   = 1'b0;
  logic                  nrst  = 1'b0;
  mars_pkg::mars_req_t   req   = '0;
  logic [10:0]           pc    = 11'h000;
  logic [7:0]            tp    = 8'h00;
  logic [15:0]           rdata = 16'h0000;
  logic [7:0]            lf    = 8'h2C;
  logic [7:0]            acc_m;
  logic [7:0]            lat_m;
  mars_pkg::mars_flags_t flg_m;
  int                    n_errors = 0;
  int                    compares = 0;
  wire logic [10:0]      prog_addr_q;
  wire logic             prog_rd_q;
  wire logic [7:0]       acc_q;
  wire mars_pkg::mars_flags_t flags_q;
  wire logic [7:0]       table_high_latch_q;
  wire logic             mem_wr_q;
  wire logic [7:0]       mem_wdata_q;
  wire logic             skip_q;
  wire logic             busy_q;
  // Boundary cases: op, memory byte, immediate, bit select.
  logic [31:0] dir [16] = '{32'h0D010000, 32'h0D000000, 32'h0FFF0000,
    32'h10FF0000, 32'h0E010000, 32'h11800007, 32'h12800007, 32'h127F0007,
    32'h13000000, 32'h14000000, 32'h1D008000, 32'h0C000100, 32'h08FF0000,
    32'h16000007, 32'h15000000, 32'h1E000000};

  always #2.5 clk = ~clk;

  mars_alu dut_u
  (
    .clk(clk), .nrst(nrst), .req(req), .prog_counter(pc),
    .table_pointer(tp), .prog_rdata(rdata), .prog_addr_q(prog_addr_q),
    .prog_rd_q(prog_rd_q), .acc_q(acc_q), .flags_q(flags_q),
    .table_high_latch_q(table_high_latch_q), .mem_wr_q(mem_wr_q),
    .mem_wdata_q(mem_wdata_q), .skip_q(skip_q), .busy_q(busy_q)
  );

  // ==========================================================================
  // Tasks
  // ==========================================================================
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : rnd

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task automatic wrap_up();
    $display("counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic reset_dut();
    req.valid = 1'b0;
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    check(acc_q === 8'h00 && flags_q === 4'h0 && mem_wr_q === 1'b0
      && skip_q === 1'b0 && busy_q === 1'b0 && prog_rd_q === 1'b0
      && table_high_latch_q === 8'h00, "reset values");
    acc_m = 8'h00;
    flg_m = '0;
    lat_m = 8'h00;
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    $display("test reset done");
  endtask : reset_dut

  // The request stays up through a busy slot, so refusal is exercised too.
  task automatic exec(input logic [4:0] op, input logic [7:0] m,
                      input logic [7:0] im, input logic [2:0] bs);
    int                    bw;
    int                    r;
    int                    sr;
    logic [7:0]            src;
    logic [7:0]            res;
    logic [7:0]            ea;
    logic [15:0]           w;
    logic                  sk;
    logic                  tb;
    mars_pkg::mars_flags_t f;
    w = {rnd(), rnd()};
    pc = w[15:5];
    tp = rnd();
    w = {rnd(), rnd()};
    req.valid = 1'b1;
    req.op = mars_pkg::mars_op_t'(op);
    req.bit_sel = bs;
    req.mem_data = m;
    req.imm_data = im;
    src = (op == 5'h0C || op == 5'h1D) ? im : m;
    bw = (op < 5'h0A && !flg_m.carry) ? 1 : 0;
    r = int'(acc_m) - int'(src) - bw;
    sr = int'($signed(acc_m)) - int'($signed(src)) - bw;
    tb = op == 5'h19 || op == 5'h1A;
    case (op)
      5'h01: res = {m[6:0], m[7]};
      5'h02, 5'h03: res = {m[6:0], flg_m.carry};
      5'h04, 5'h05: res = {m[0], m[7:1]};
      5'h06, 5'h07: res = {flg_m.carry, m[7:1]};
      5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C: res = r[7:0];
      5'h0D, 5'h0E: res = m - 8'h01;
      5'h0F, 5'h10: res = m + 8'h01;
      5'h14: res = m;
      5'h15: res = 8'hFF;
      5'h16: res = m | (8'h01 << bs);
      5'h17, 5'h18: res = {m[3:0], m[7:4]};
      5'h19, 5'h1A: res = w[7:0];
      5'h1B, 5'h1C, 5'h1D: res = acc_m ^ src;
      default: res = acc_m;
    endcase
    sk = op inside {[5'h0D:5'h10]} ? res == 8'h00 : op == 5'h11 ? m[bs]
      : op == 5'h12 ? !m[bs] : (op inside {5'h13, 5'h14}) && m == 8'h00;
    f = flg_m;
    if (SUBS[op])
    begin
      f.carry = r >= 0;
      f.nibble_carry_flag = int'(acc_m[3:0]) - int'(src[3:0]) - bw >= 0;
      f.signed_wrap_flag = sr < -128 || sr > 127;
    end
    if (op == 5'h02 || op == 5'h03) f.carry = m[7];
    if (op == 5'h06 || op == 5'h07) f.carry = m[0];
    if (SUBS[op] || op > 5'h1A && op < 5'h1E) f.zero = res == 8'h00;
    ea = ACCD[op] ? res : acc_m;
    @(posedge clk);
    @(negedge clk);
    check(acc_q === ea, "accumulator");
    check(flags_q === f, "flags");
    check(mem_wr_q === (MEMD[op] && !tb), "write");
    if (MEMD[op] && !tb) check(mem_wdata_q === res, "data");
    check(skip_q === sk, "skip");
    check(busy_q === (SKIPS[op] || tb), "busy");
    if (tb) check(prog_rd_q === 1'b1 && prog_addr_q ===
      {op == 5'h1A ? 3'b111 : pc[10:8], tp}, "table address");
    if (tb) rdata = w;
    if (SKIPS[op] || tb)
    begin
      @(negedge clk);
      if (tb) lat_m = w[15:8];
      check(mem_wr_q === tb && (!tb || mem_wdata_q === res), "word");
      check(acc_q === ea && !skip_q && !busy_q, "held request");
    end
    check(table_high_latch_q === lat_m && !prog_rd_q, "latch");
    acc_m = ea;
    flg_m = f;
  endtask : exec

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    reset_dut();
    foreach (dir[i])
      exec(dir[i][28:24], dir[i][23:16], dir[i][15:8], dir[i][2:0]);
    $display("test directed done");
    for (int i = 0; i < 400; i++)
      exec(5'(rnd()), rnd(), rnd(), 3'(rnd()));
    $display("test random done");
    reset_dut();
    for (int i = 0; i < 100; i++)
      exec(5'(rnd()), rnd(), rnd(), 3'(rnd()));
    $display("test after second reset done");
    wrap_up();
  end

  // The run needs at most about 1078 cycles; this 10000-cycle span leaves ample margin.
  initial
  begin
    #50000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : mars_alu_bench
